// file: evsync_pkg.sv
// Purpose: Constants for the DMA event synchronisation and capture block
// Assumes: 32-bit AHB-Lite register port, one word per register
// Notes:   Channel numbers give the fixed event wiring
package evsync_pkg;
  localparam int          NUM_CH      = 64;
  localparam int          PRIO_W      = 2;
  localparam int          ADDR_W      = 12;
  // Register byte offsets
  localparam logic [11:0] OFF_FLAG_LO = 12'h000;
  localparam logic [11:0] OFF_FLAG_HI = 12'h004;
  localparam logic [11:0] OFF_FCLR_LO = 12'h008;
  localparam logic [11:0] OFF_FCLR_HI = 12'h00C;
  localparam logic [11:0] OFF_EN_LO   = 12'h010;
  localparam logic [11:0] OFF_EN_HI   = 12'h014;
  localparam logic [11:0] OFF_IRQ_ST  = 12'h018;
  localparam logic [11:0] OFF_IRQ_EN  = 12'h01C;
  localparam logic [11:0] OFF_IRQ_CLR = 12'h020;
  localparam logic [11:0] OFF_PRAM    = 12'h100;
  localparam logic [11:0] PRAM_MASK   = 12'hF00;
  // Reset values
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;
  localparam logic [1:0]  RST_PRIO    = 2'h0;
  // Interrupt status bit positions
  localparam int          IRQ_OVERRUN = 0;
  localparam int          IRQ_ISSUED  = 1;
  localparam int          IRQ_W       = 2;
  // Fixed channel wiring
  localparam int          CH_HOST     = 0;
  localparam int          CH_TIMER0   = 1;
  localparam int          CH_TIMER1   = 2;
  localparam int          CH_SDRAM    = 3;
  localparam int          CH_PIN4     = 4;
  localparam int          CH_GPIO0    = 8;
  localparam int          CH_SER0_TX  = 12;
  localparam int          CH_SER0_RX  = 13;
  localparam int          CH_SER1_TX  = 14;
  localparam int          CH_SER1_RX  = 15;
  localparam int          CH_TIMER2   = 19;
  localparam int          CH_GPIO8    = 48;
  // Channels that have a source at all
  localparam logic [63:0] WIRED_MASK  = 64'h00FF_0000_0008_FFFF;
endpackage : evsync_pkg

// file: dma_event_sync_capture.sv
// Purpose: Latch DMA synchronisation events and issue prioritised requests
// Assumes: Event inputs synchronous to ref_clk; an event is a rising edge
// Notes:   Registers over AHB-Lite; reads take one wait state
`timescale 1ns/1ns
// Functional notes
// - Sixty-four independent event-triggered channels
// - Each channel in WIRED_MASK has one fixed event source; the rest are tied low
// - Flags set even when channel disabled
// - Per-channel priority from parameter RAM
// - SDRAM refresh tick drives channel three
// - Pin events four-seven drive channels four-seven
module dma_event_sync_capture #(
  parameter int NUM_CH = evsync_pkg::NUM_CH,
  parameter int PRIO_W = evsync_pkg::PRIO_W
) (
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic              host_core_event,
  input  wire logic              timer_zero_event,
  input  wire logic              timer_one_event,
  input  wire logic              timer_two_event,
  input  wire logic              sdram_refresh_tick,
  input  wire logic              pin_event_four,
  input  wire logic              pin_event_five,
  input  wire logic              pin_event_six,
  input  wire logic              pin_event_seven,
  input  wire logic [3:0]        gpio_event_low,
  input  wire logic [7:0]        gpio_event_high,
  input  wire logic              serial0_tx_event,
  input  wire logic              serial0_rx_event,
  input  wire logic              serial1_tx_event,
  input  wire logic              serial1_rx_event,
  output logic                   req_valid,
  output logic [5:0]             req_chan,
  output logic [PRIO_W-1:0]      req_prio,
  input  wire logic              req_ready,
  output logic                   irq
);
  localparam int IRQ_W_L = evsync_pkg::IRQ_W;

  logic                   rst_s1_q;
  logic                   rst_n;
  logic [NUM_CH-1:0]      ev_vec;
  logic [NUM_CH-1:0]      ev_prev_q;
  logic [NUM_CH-1:0]      ev_rise;
  logic [NUM_CH-1:0]      flag_q;
  logic [NUM_CH-1:0]      flag_d;
  logic [NUM_CH-1:0]      enable_q;
  logic [NUM_CH-1:0]      sw_clr;
  logic [NUM_CH-1:0]      launch_clr;
  logic [NUM_CH-1:0]      pend;
  logic [PRIO_W-1:0]      prio_ram [NUM_CH];
  logic [IRQ_W_L-1:0]     irq_st_q;
  logic [IRQ_W_L-1:0]     irq_en_q;
  logic [IRQ_W_L-1:0]     irq_clr;
  logic [IRQ_W_L-1:0]     irq_set;
  logic                   best_found;
  logic [5:0]             best_chan;
  logic [PRIO_W-1:0]      best_prio;
  logic                   launch;
  logic                   addr_ok;
  logic                   wr_pend_q;
  logic                   rd_pend_q;
  logic [11:0]            dp_addr_q;
  logic [31:0]            rd_word;
  logic                   wr_now;

  // Reset release through two flops
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // Fixed source wiring; unlisted channels stay tied low
  always_comb begin
    ev_vec                           = '0;
    ev_vec[evsync_pkg::CH_HOST]      = host_core_event;
    ev_vec[evsync_pkg::CH_TIMER0]    = timer_zero_event;
    ev_vec[evsync_pkg::CH_TIMER1]    = timer_one_event;
    ev_vec[evsync_pkg::CH_SDRAM]     = sdram_refresh_tick;
    ev_vec[evsync_pkg::CH_PIN4]      = pin_event_four;
    ev_vec[evsync_pkg::CH_PIN4+1]    = pin_event_five;
    ev_vec[evsync_pkg::CH_PIN4+2]    = pin_event_six;
    ev_vec[evsync_pkg::CH_PIN4+3]    = pin_event_seven;
    ev_vec[evsync_pkg::CH_GPIO0+:4]  = gpio_event_low;
    ev_vec[evsync_pkg::CH_SER0_TX]   = serial0_tx_event;
    ev_vec[evsync_pkg::CH_SER0_RX]   = serial0_rx_event;
    ev_vec[evsync_pkg::CH_SER1_TX]   = serial1_tx_event;
    ev_vec[evsync_pkg::CH_SER1_RX]   = serial1_rx_event;
    ev_vec[evsync_pkg::CH_TIMER2]    = timer_two_event;
    ev_vec[evsync_pkg::CH_GPIO8+:8]  = gpio_event_high;
  end

  // Level sources would refire every cycle, so only edges count
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) ev_prev_q <= '0;
    else        ev_prev_q <= ev_vec;
  end
  assign ev_rise = ev_vec & ~ev_prev_q & evsync_pkg::WIRED_MASK;

  // AHB decode
  assign addr_ok = hsel && htrans[1] && hready;
  assign wr_now  = wr_pend_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      dp_addr_q <= '0;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      rd_pend_q <= addr_ok && !hwrite;
      if (addr_ok) dp_addr_q <= haddr[11:0];
    end
  end

  // Reads stall one cycle so a preceding write is already visible
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= evsync_pkg::RST_WORD;
    end else begin
      hreadyout <= !(addr_ok && !hwrite);
      hresp     <= 1'b0;
      if (rd_pend_q) hrdata <= rd_word;
    end
  end

  always_comb begin
    rd_word = evsync_pkg::RST_WORD;
    if ((dp_addr_q & evsync_pkg::PRAM_MASK) == evsync_pkg::OFF_PRAM) begin
      rd_word[PRIO_W-1:0] = prio_ram[dp_addr_q[7:2]];
    end else begin
      case (dp_addr_q)
        evsync_pkg::OFF_FLAG_LO: rd_word = flag_q[31:0];
        evsync_pkg::OFF_FLAG_HI: rd_word = flag_q[63:32];
        evsync_pkg::OFF_EN_LO:   rd_word = enable_q[31:0];
        evsync_pkg::OFF_EN_HI:   rd_word = enable_q[63:32];
        evsync_pkg::OFF_IRQ_ST:  rd_word[IRQ_W_L-1:0] = irq_st_q;
        evsync_pkg::OFF_IRQ_EN:  rd_word[IRQ_W_L-1:0] = irq_en_q;
        default:                 rd_word = evsync_pkg::RST_WORD;
      endcase
    end
  end

  // Write-one-to-clear strobes
  always_comb begin
    sw_clr  = '0;
    irq_clr = '0;
    if (wr_now && dp_addr_q == evsync_pkg::OFF_FCLR_LO) sw_clr[31:0]  = hwdata;
    if (wr_now && dp_addr_q == evsync_pkg::OFF_FCLR_HI) sw_clr[63:32] = hwdata;
    if (wr_now && dp_addr_q == evsync_pkg::OFF_IRQ_CLR) begin
      irq_clr = hwdata[IRQ_W_L-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= '0;
      irq_en_q <= '0;
    end else if (wr_now) begin
      if (dp_addr_q == evsync_pkg::OFF_EN_LO) enable_q[31:0]  <= hwdata;
      if (dp_addr_q == evsync_pkg::OFF_EN_HI) enable_q[63:32] <= hwdata;
      if (dp_addr_q == evsync_pkg::OFF_IRQ_EN) irq_en_q <= hwdata[IRQ_W_L-1:0];
    end
  end

  // Parameter RAM holds the priority field of each channel
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_CH; i++) prio_ram[i] <= evsync_pkg::RST_PRIO;
    end else if (wr_now &&
                 (dp_addr_q & evsync_pkg::PRAM_MASK) == evsync_pkg::OFF_PRAM) begin
      prio_ram[dp_addr_q[7:2]] <= hwdata[PRIO_W-1:0];
    end
  end

  // Flags catch every edge regardless of enable; a set beats any clear
  assign flag_d = (flag_q & ~sw_clr & ~launch_clr) | ev_rise;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) flag_q <= '0;
    else        flag_q <= flag_d;
  end

  // Lowest priority code wins, lower channel breaks ties
  assign pend = flag_q & enable_q;
  always_comb begin
    best_found = 1'b0;
    best_chan  = '0;
    best_prio  = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (pend[i] && (!best_found || prio_ram[i] <= best_prio)) begin
        best_found = 1'b1;
        best_chan  = 6'(i);
        best_prio  = prio_ram[i];
      end
    end
  end

  assign launch = best_found && (!req_valid || req_ready);
  always_comb begin
    launch_clr = '0;
    if (launch) launch_clr[best_chan] = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_valid <= 1'b0;
      req_chan  <= '0;
      req_prio  <= '0;
    end else if (launch) begin
      req_valid <= 1'b1;
      req_chan  <= best_chan;
      req_prio  <= best_prio;
    end else if (req_ready) begin
      req_valid <= 1'b0;
    end
  end

  // Interrupt status: overrun when an edge hits a pending flag
  always_comb begin
    irq_set                       = '0;
    irq_set[evsync_pkg::IRQ_OVERRUN] = |(ev_rise & flag_q);
    irq_set[evsync_pkg::IRQ_ISSUED]  = req_valid && req_ready;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_st_q <= '0;
      irq <= 1'b0;
    end else begin
      irq_st_q <= (irq_st_q & ~irq_clr) | irq_set;
      irq      <= |(((irq_st_q & ~irq_clr) | irq_set) & irq_en_q);
    end
  end

  // Checks
  chk_no_unwired: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (flag_q & ~evsync_pkg::WIRED_MASK) == '0)
    else $error("flag set on channel with no source");
  chk_flag_no_enable: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(timer_zero_event) |=> flag_q[evsync_pkg::CH_TIMER0])
    else $error("timer zero edge not latched");
  chk_sdram_ch3: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(sdram_refresh_tick) |=> flag_q[3])
    else $error("refresh tick not on channel three");
  chk_pin4_ch4: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(pin_event_four) |=> flag_q[4])
    else $error("pin event four not on channel four");
  chk_pin7_ch7: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(pin_event_seven) |=> flag_q[7])
    else $error("pin event seven not on channel seven");
  chk_ser0rx_ch13: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(serial0_rx_event) |=> flag_q[13])
    else $error("serial0 receive not on channel thirteen");
  chk_prio_match: assert property (@(posedge ref_clk) disable iff (!rst_n)
    launch |=> req_prio == $past(prio_ram[best_chan]))
    else $error("request priority differs from parameter RAM");
  chk_req_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    req_valid && !req_ready |=> req_valid && $stable(req_chan))
    else $error("request dropped before acceptance");
  chk_issue_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
    launch && !ev_rise[best_chan] |=> !flag_q[$past(best_chan)])
    else $error("issued flag not cleared");
  cov_launch:  cover property (@(posedge ref_clk) disable iff (!rst_n) launch);
  cov_overrun: cover property (@(posedge ref_clk) disable iff (!rst_n)
    irq_set[evsync_pkg::IRQ_OVERRUN]);
  cov_stall:   cover property (@(posedge ref_clk) disable iff (!rst_n)
    req_valid && !req_ready ##1 req_valid && req_ready);
endmodule : dma_event_sync_capture

// file: xfer_sink.sv
// Purpose: Transfer-logic stand-in that accepts DMA requests
// Assumes: A request is held until the edge at which it is accepted
// Notes:   stall holds acceptance off so that a backlog of events builds up
`timescale 1ns/1ns
module xfer_sink (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        stall,
  input  wire logic        req_valid,
  input  wire logic [5:0]  req_chan,
  output logic             req_ready,
  output logic [11:0]      hist_q
);
  assign req_ready = !stall;
  // Last two accepted channels, oldest in the upper half
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) hist_q <= 12'h000;
    else if (req_valid && req_ready) hist_q <= {hist_q[5:0], req_chan};
  end
endmodule : xfer_sink

// file: testbench.sv
// Purpose: Self-checking bench for the DMA event capture block
// Assumes: One AHB-Lite master, hready fed back from hreadyout
// Notes:   Event sources packed into one vector, channel worked out per bit
`timescale 1ns/1ns
module testbench;
  logic        ref_clk;
  logic        resetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [24:0] ev;
  logic        req_valid;
  logic [5:0]  req_chan;
  logic [1:0]  req_prio;
  logic        req_ready;
  logic        irq;
  logic        stall;
  logic [11:0] hist_q;
  logic [31:0] rd;
  logic [63:0] exp_flags;
  int          fails;
  int          cmp_count;
  int          ch;

  dma_event_sync_capture i_dma_event_sync_capture (
    .ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .host_core_event(ev[0]), .timer_zero_event(ev[1]), .timer_one_event(ev[2]),
    .sdram_refresh_tick(ev[3]), .pin_event_four(ev[4]), .pin_event_five(ev[5]),
    .pin_event_six(ev[6]), .pin_event_seven(ev[7]), .gpio_event_low(ev[11:8]),
    .serial0_tx_event(ev[12]), .serial0_rx_event(ev[13]), .serial1_tx_event(ev[14]),
    .serial1_rx_event(ev[15]), .timer_two_event(ev[16]), .gpio_event_high(ev[24:17]),
    .req_valid(req_valid), .req_chan(req_chan), .req_prio(req_prio),
    .req_ready(req_ready), .irq(irq));
  xfer_sink i_xfer_sink (
    .ref_clk(ref_clk), .rst_n(resetn), .stall(stall), .req_valid(req_valid),
    .req_chan(req_chan), .req_ready(req_ready), .hist_q(hist_q));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Called just after a rising edge; waits on hready, never on a fixed count
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h00000, a};
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check("hresp", {31'h0, hresp}, 32'h0000_0000);
  endtask : bus

  task automatic fire(input logic [24:0] m);
    ev <= m;
    @(posedge ref_clk);
    ev <= 25'h0000000;
    repeat (3) @(posedge ref_clk);
  endtask : fire

  // Bit i of ev to the channel that it is wired to
  function automatic int chan_of(input int i);
    if (i < 16) return i;
    if (i == 16) return 19;
    return 48 + i - 17;
  endfunction : chan_of

  initial begin
    #200000;
    fails++;
    report_and_stop();
  end

  initial begin
    resetn = 1'b0;
    hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hwdata = 32'h0;
    ev = 25'h0000000;
    stall = 1'b0;
    fails = 0;
    cmp_count = 0;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    bus(1'b0, evsync_pkg::OFF_EN_LO, 32'h0);
    check("enable_low reset", rd, evsync_pkg::RST_WORD);
    bus(1'b0, 12'h040, 32'h0);
    check("unmapped read", rd, 32'h0000_0000);
    // Every source alone, with all channels disabled
    for (int i = 0; i < 25; i++) begin
      fire(25'h1 << i);
      ch = chan_of(i);
      exp_flags = 64'h1 << ch;
      bus(1'b0, evsync_pkg::OFF_FLAG_LO, 32'h0);
      check("event_flag_low", rd, exp_flags[31:0]);
      bus(1'b0, evsync_pkg::OFF_FLAG_HI, 32'h0);
      check("event_flag_high", rd, exp_flags[63:32]);
      bus(1'b1, evsync_pkg::OFF_FCLR_LO, 32'hFFFF_FFFF);
      bus(1'b1, evsync_pkg::OFF_FCLR_HI, 32'hFFFF_FFFF);
    end
    fire(25'h1FF_FFFF);
    bus(1'b1, evsync_pkg::OFF_FLAG_LO, 32'h0000_0000);
    bus(1'b0, evsync_pkg::OFF_FLAG_LO, 32'h0);
    check("all flags low", rd, 32'h0008_FFFF);
    bus(1'b0, evsync_pkg::OFF_FLAG_HI, 32'h0);
    check("all flags high", rd, 32'h00FF_0000);
    bus(1'b1, evsync_pkg::OFF_FCLR_LO, 32'hFFFF_FFFF);
    bus(1'b1, evsync_pkg::OFF_FCLR_HI, 32'hFFFF_FFFF);
    // Channel 5 outranks channel 3 by its priority code despite the higher number
    bus(1'b1, evsync_pkg::OFF_PRAM + 12'h00C, 32'h0000_0001);
    bus(1'b1, evsync_pkg::OFF_PRAM + 12'h014, 32'h0000_0000);
    bus(1'b0, evsync_pkg::OFF_PRAM + 12'h00C, 32'h0);
    check("prio ch3", rd, 32'h0000_0001);
    bus(1'b1, evsync_pkg::OFF_IRQ_EN, 32'h0000_0002);
    stall <= 1'b1;
    bus(1'b1, evsync_pkg::OFF_EN_LO, 32'h0000_0028);
    fire(25'h0000028);
    check("prio of first", {30'h0, req_prio}, 32'h0000_0000);
    check("chan of first", {26'h0, req_chan}, 32'h0000_0005);
    stall <= 1'b0;
    repeat (10) @(posedge ref_clk);
    check("issue order", {20'h0, hist_q}, {20'h0, 6'h05, 6'h03});
    bus(1'b0, evsync_pkg::OFF_FLAG_LO, 32'h0);
    check("flags after issue", rd, 32'h0000_0000);
    bus(1'b0, evsync_pkg::OFF_IRQ_ST, 32'h0);
    check("irq status", rd, 32'h0000_0002);
    check("irq raised", {31'h0, irq}, 32'h0000_0001);
    bus(1'b1, evsync_pkg::OFF_IRQ_CLR, 32'h0000_0002);
    repeat (3) @(posedge ref_clk);
    check("irq cleared", {31'h0, irq}, 32'h0000_0000);
    // A second edge on a flag still pending is merged and flagged as overrun
    fire(25'h0000002);
    fire(25'h0000002);
    bus(1'b0, evsync_pkg::OFF_IRQ_ST, 32'h0);
    check("overrun status", rd, 32'h0000_0001);
    check("irq masked", {31'h0, irq}, 32'h0000_0000);
    report_and_stop();
  end
endmodule : testbench
